// ### pkg/bsec_pkg.sv
// Function
// RULE1 - code 6CH counts port IO transactions only
// RULE2 - code 6DH counts each deferred transaction
// RULE3 - code 6EH counts full cache-line transactions
// RULE4 - code 6FH counts every memory transaction
// RULE5 - memory count equals line+partial+invalidate
// RULE6 - code 70H counts transactions of any type
// RULE7 - code 77H counts snoop responses by type
// RULE8 - own qualifier: own responses, own transactions
// RULE9 - every-agent qualifier: all observed snoop responses
// RULE10 - code 78H counts other-core L1D snoops
// RULE11 - other-core read hitting Exclusive gives Shared
// RULE12 - ownership read hitting Exclusive/Shared invalidates
// RULE13 - Modified hit may defer its state change
// RULE14 - snoops use store port, stalling stores
// RULE15 - code 7AH counts bus cycles driving shared-hit
// RULE16 - count only for known code and admitted qualifier
// RULE17 - same-cycle occurrences summed, none lost
package bsec_pkg;
  // ==========================================
  // event codes
  localparam logic [7:0] EV_PORT_IO  = 8'h6C;  // port io transactions
  localparam logic [7:0] EV_DEFER    = 8'h6D;  // deferred transactions
  localparam logic [7:0] EV_LINE     = 8'h6E;  // full line transactions
  localparam logic [7:0] EV_MEMORY   = 8'h6F;  // memory transactions
  localparam logic [7:0] EV_ANY      = 8'h70;  // every transaction
  localparam logic [7:0] EV_SNP_RESP = 8'h77;  // snoop responses
  localparam logic [7:0] EV_XCORE    = 8'h78;  // cross-core snoops
  localparam logic [7:0] EV_HIT_DRV  = 8'h7A;  // shared-hit drive cycles
  // ==========================================
  // apb register map
  localparam int         ADDR_W      = 8;      // apb address width
  localparam logic [7:0] OFS_CTRL    = 8'h00;  // control
  localparam logic [7:0] OFS_COUNT   = 8'h04;  // counter value
  localparam logic [7:0] OFS_STATUS  = 8'h08;  // sticky status, read only
  localparam logic [7:0] OFS_CLEAR   = 8'h0C;  // status clear, write only
  localparam logic [7:0] OFS_ENABLE  = 8'h10;  // interrupt enable
  // ==========================================
  // control fields
  localparam int CTL_CODE_LSB = 0;   // event code, 8 bits
  localparam int CTL_RUN      = 8;   // counting enable
  localparam int CTL_ALL      = 9;   // every agent, transactions and snoop responses
  localparam int CTL_RSP_LSB  = 10;  // snoop response type mask, 3 bits
  localparam int CTL_XRD      = 13;  // count cross-core read snoops
  localparam int CTL_XRFO     = 14;  // count cross-core ownership snoops
  localparam int CTL_W        = 15;  // implemented control bits
  localparam logic [14:0] CTL_RST = 15'h0000;  // control reset value
  // ==========================================
  // status and interrupt bits
  localparam int ST_OVF   = 0;  // counter wrapped
  localparam int ST_DEFER = 1;  // modified-line snoop deferred
  localparam int ST_W     = 2;  // status width
  localparam logic [1:0] ST_RST = 2'h0;  // status reset value
  // ==========================================
  // timing
  localparam int BUS_DIV_DEF = 2;  // core clocks per bus cycle
  // ==========================================
  // cache line states, gray order I-S-E-M
  typedef enum logic [1:0] {
    LN_I = 2'b00,
    LN_S = 2'b01,
    LN_E = 2'b11,
    LN_M = 2'b10
  } bsec_line_t;
  // deferred update tracker
  typedef enum logic [0:0] {
    DF_IDLE = 1'b0,
    DF_WAIT = 1'b1
  } bsec_defer_t;
endpackage : bsec_pkg

// ### hdl/bsec_snoop_port.sv
`timescale 1ns/1ps
// ==========================================
// cross-core snoop service on the l1d store port
module bsec_snoop_port
  import bsec_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       snp_valid,    // other-core snoop this cycle
  input  wire logic       snp_rfo,      // snoop is read_for_ownership
  input  wire bsec_line_t snp_state,    // current state of snooped line
  input  wire logic       store_req,    // ordinary store wants the port
  output logic            store_grant,  // store may use the port
  output logic            state_wr,     // line state write pulse
  output bsec_line_t      state_new,    // state to write
  output logic            defer_evt     // modified hit was deferred
);
  bsec_defer_t defer;    // deferred update pending
  logic        pend_rfo;  // pending update is an ownership snoop
  // apply the deferred change only on an idle port
  wire apply = (defer == DF_WAIT) & ~snp_valid & ~store_req;
  wire hit_m = snp_valid & (snp_state == LN_M);
  // state chosen for a live snoop
  wire bsec_line_t live_state =
    (snp_rfo & (snp_state == LN_E || snp_state == LN_S)) ? LN_I :  // [RULE12]
    (~snp_rfo & (snp_state == LN_E)) ? LN_S :                        // [RULE11]
    snp_state;
  // port arbitration and line state update
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      store_grant <= 1'b0;
      state_wr    <= 1'b0;
      state_new   <= LN_I;
      defer_evt   <= 1'b0;
      defer       <= DF_IDLE;
      pend_rfo    <= 1'b0;
    end else begin
      // snoops own the port; stores wait
      store_grant <= store_req & ~snp_valid;  // [RULE14]
      state_wr    <= (snp_valid & ~hit_m) | apply;
      state_new   <= apply ? (pend_rfo ? LN_I : LN_S) : live_state;
      defer_evt   <= hit_m;
      case (defer)
        DF_IDLE: begin
          if (hit_m) begin  // [RULE13]
            defer    <= DF_WAIT;
            pend_rfo <= snp_rfo;
          end
        end
        DF_WAIT: begin
          if (hit_m) begin
            pend_rfo <= pend_rfo | snp_rfo;
          end else if (apply) begin
            defer    <= DF_IDLE;
            pend_rfo <= 1'b0;
          end
        end
        default: begin
          defer <= DF_IDLE;
        end
      endcase
    end
  end
endmodule : bsec_snoop_port

// ### hdl/bsec_top.sv
`timescale 1ns/1ps
// ==========================================
// bus and snoop event counter
module bsec_top
  import bsec_pkg::*;
#(
  parameter int BUS_DIV = BUS_DIV_DEF  // core clocks per bus cycle
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  // transaction classes, one-cycle pulses, with own-core flags
  input  wire logic              port_io_transaction_event,
  input  wire logic              port_io_self,
  input  wire logic              deferred_transaction_event,
  input  wire logic              deferred_self,
  input  wire logic              full_line_transaction_event,
  input  wire logic              full_line_self,
  input  wire logic              partial_transaction_event,
  input  wire logic              partial_self,
  input  wire logic              invalidate_transaction_event,
  input  wire logic              invalidate_self,
  input  wire logic              other_transaction_event,
  input  wire logic              other_self,
  // snoop responses on the bus
  input  wire logic              external_snoop_response_event,
  input  wire logic [1:0]        snoop_resp_type,
  input  wire logic              snoop_resp_by_self,
  input  wire logic              snoop_req_by_self,
  // cross-core snoops of this l1d
  input  wire logic              cross_core_snoop_event,
  input  wire logic              read_for_ownership,
  input  wire bsec_line_t        snoop_line_state,
  input  wire logic              store_req,
  output logic                   store_grant,
  output logic                   line_state_wr,
  output bsec_line_t             line_state_new,
  // this core drives the shared-hit response
  input  wire logic              shared_hit_drive_event
);
  // ==========================================
  // register state
  logic [CTL_W-1:0] ctrl;        // control register
  logic [31:0]      count;       // event counter
  logic [ST_W-1:0]  status;      // sticky status
  logic [ST_W-1:0]  int_enable;  // interrupt enable
  logic [15:0]      div_cnt;     // bus cycle divider
  logic             bus_tick;    // one pulse per bus cycle
  logic             defer_evt;   // from snoop unit

  // ==========================================
  // apb decode
  wire setup_acc = psel & penable & ~pready;  // access, first cycle
  wire acc_done  = psel & penable & pready;   // completing edge
  wire wr_en     = acc_done & pwrite;         // write takes effect
  wire hit_ctrl  = (paddr == OFS_CTRL);
  wire hit_count = (paddr == OFS_COUNT);
  wire hit_stat  = (paddr == OFS_STATUS);
  wire hit_clr   = (paddr == OFS_CLEAR);
  wire hit_ena   = (paddr == OFS_ENABLE);
  wire hit_any   = hit_ctrl | hit_count | hit_stat | hit_clr | hit_ena;
  wire wr_ctrl   = wr_en & hit_ctrl;
  wire wr_count  = wr_en & hit_count;
  wire wr_clr    = wr_en & hit_clr;
  wire wr_ena    = wr_en & hit_ena;

  // read mux; clear register reads as zero
  wire [31:0] rd_data =
    hit_ctrl  ? {{(32-CTL_W){1'b0}}, ctrl} :
    hit_count ? count :
    hit_stat  ? {{(32-ST_W){1'b0}}, status} :
    hit_ena   ? {{(32-ST_W){1'b0}}, int_enable} :
    32'h0000_0000;

  // ==========================================
  // control fields
  wire [7:0] code    = ctrl[CTL_CODE_LSB +: 8];
  wire       run     = ctrl[CTL_RUN];
  wire       all_ag  = ctrl[CTL_ALL];
  wire [2:0] rsp_msk = ctrl[CTL_RSP_LSB +: 3];
  wire       x_rd    = ctrl[CTL_XRD];
  wire       x_rfo   = ctrl[CTL_XRFO];

  // ==========================================
  // qualified occurrences, own core unless every agent chosen
  wire q_io    = port_io_transaction_event & (all_ag | port_io_self);
  wire q_def   = deferred_transaction_event & (all_ag | deferred_self);
  wire q_line  = full_line_transaction_event & (all_ag | full_line_self);
  wire q_part  = partial_transaction_event & (all_ag | partial_self);
  wire q_inval = invalidate_transaction_event & (all_ag | invalidate_self);
  wire q_other = other_transaction_event & (all_ag | other_self);

  // snoop response qualifier by responder and requester
  wire snp_own   = snoop_resp_by_self & snoop_req_by_self;      // [RULE8]
  wire snp_agent = all_ag | snp_own;                            // [RULE9]
  wire snp_type  = (snoop_resp_type != 2'b11) & rsp_msk[snoop_resp_type];
  wire q_snp     = external_snoop_response_event & snp_type & snp_agent;  // [RULE7]

  // cross-core snoop qualified by snoop type
  wire x_type = read_for_ownership ? x_rfo : x_rd;
  wire q_x    = cross_core_snoop_event & x_type;               // [RULE10]

  // shared-hit drive sampled once per bus cycle
  wire q_hit = shared_hit_drive_event & bus_tick;              // [RULE15]

  // ==========================================
  // per-event sums of same-cycle occurrences
  wire [2:0] s_io    = {2'b00, q_io};                          // [RULE1]
  wire [2:0] s_def   = {2'b00, q_def};                         // [RULE2]
  wire [2:0] s_line  = {2'b00, q_line};                        // [RULE3]
  wire [2:0] s_mem   = s_line + {2'b00, q_part} + {2'b00, q_inval};  // [RULE4] [RULE5]
  wire [2:0] s_any   = s_mem + s_io + s_def + {2'b00, q_other}; // [RULE6] [RULE17]
  wire [2:0] s_snp   = {2'b00, q_snp};
  wire [2:0] s_x     = {2'b00, q_x};
  wire [2:0] s_hit   = {2'b00, q_hit};

  // code selection; unknown codes add nothing
  wire [2:0] sel_inc =
    (code == EV_PORT_IO)  ? s_io   :
    (code == EV_DEFER)    ? s_def  :
    (code == EV_LINE)     ? s_line :
    (code == EV_MEMORY)   ? s_mem  :
    (code == EV_ANY)      ? s_any  :
    (code == EV_SNP_RESP) ? s_snp  :
    (code == EV_XCORE)    ? s_x    :
    (code == EV_HIT_DRV)  ? s_hit  :
    3'h0;
  wire [2:0] inc = run ? sel_inc : 3'h0;                       // [RULE16]

  // counter sum with carry out
  wire [32:0] sum        = {1'b0, count} + {30'h0000_0000, inc};
  wire        ovf_evt    = sum[32] & ~wr_count;
  wire [31:0] next_count = wr_count ? pwdata : sum[31:0];      // [RULE17]

  // ==========================================
  // sticky status: new events win over a clear
  wire [ST_W-1:0] evt_bits    = {defer_evt, ovf_evt};
  wire [ST_W-1:0] clr_bits    = wr_clr ? pwdata[ST_W-1:0] : {ST_W{1'b0}};
  wire [ST_W-1:0] next_status = (status & ~clr_bits) | evt_bits;
  wire [ST_W-1:0] next_ena    = wr_ena ? pwdata[ST_W-1:0] : int_enable;
  wire            next_irq    = |(next_status & next_ena);

  // ==========================================
  // apb handshake: one wait state, registered read data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready <= setup_acc;
      // capture answer while waiting
      if (setup_acc) begin
        pslverr <= ~hit_any;
        prdata  <= pwrite ? 32'h0000_0000 : rd_data;
      end else if (acc_done) begin
        pslverr <= 1'b0;
      end
    end
  end

  // control register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= CTL_RST;
    end else if (wr_ctrl) begin
      ctrl <= pwdata[CTL_W-1:0];
    end
  end

  // counter, software write overrides increment
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 32'h0000_0000;
    end else begin
      count <= next_count;
    end
  end

  // status, enable and interrupt line
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status     <= ST_RST;
      int_enable <= ST_RST;
      irq        <= 1'b0;
    end else begin
      status     <= next_status;
      int_enable <= next_ena;
      irq        <= next_irq;
    end
  end

  // ==========================================
  // bus cycle divider
  wire div_last = (div_cnt == 16'(BUS_DIV - 1));
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt  <= 16'h0000;
      bus_tick <= 1'b0;
    end else begin
      div_cnt  <= div_last ? 16'h0000 : div_cnt + 16'h0001;
      bus_tick <= div_last;
    end
  end

  // ==========================================
  // cross-core snoop service on the store port
  bsec_snoop_port u_snoop (
    .clk         (clk),
    .rstn        (rstn),
    .snp_valid   (cross_core_snoop_event),
    .snp_rfo     (read_for_ownership),
    .snp_state   (snoop_line_state),
    .store_req   (store_req),
    .store_grant (store_grant),
    .state_wr    (line_state_wr),
    .state_new   (line_state_new),
    .defer_evt   (defer_evt)
  );
endmodule : bsec_top

// ### dv/bsec_monitor.sv
`timescale 1ns/1ps
// ==========================================
// apb and snoop-port checks on the top ports
module bsec_monitor
  import bsec_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       cross_core_snoop_event,
  input wire logic       read_for_ownership,
  input wire bsec_line_t snoop_line_state,
  input wire logic       store_req,
  input wire logic       store_grant,
  input wire logic       line_state_wr,
  input wire bsec_line_t line_state_new
);
  // ==========================================
  // one clock domain
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // snoop kinds
  wire logic xs = cross_core_snoop_event;                           // snoop this cycle
  wire logic rd_e = xs && !read_for_ownership && snoop_line_state == LN_E;
  wire logic rfo_es = xs && read_for_ownership && snoop_line_state inside {LN_E, LN_S};
  wire logic hit_m = xs && snoop_line_state == LN_M;                // modified hit
  // ==========================================
  // apb answer
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready outside second access cycle");
  a_ready_latency: assert property (psel && !penable ##1 psel && penable |=> pready)
    else $error("pready late after access phase");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // ==========================================
  // store port shared with snoops
  a_grant_blocked: assert property (xs |=> !store_grant)
    else $error("store granted during snoop service");
  a_grant_follows: assert property (store_req && !xs |=> store_grant)
    else $error("free store port not granted");
  // ==========================================
  // line state updates
  a_excl_to_shared: assert property (rd_e |=> line_state_wr && line_state_new == LN_S)
    else $error("exclusive read hit not moved to shared");
  a_rfo_invalidates: assert property (rfo_es |=>
    line_state_wr && line_state_new == LN_I)
    else $error("ownership hit not invalidated");
  a_modified_defers: assert property (hit_m |=> !line_state_wr)
    else $error("modified hit written at once");
endmodule : bsec_monitor

bind bsec_top bsec_monitor u_mon (.clk, .rstn, .psel, .penable, .pready, .pslverr,
  .cross_core_snoop_event, .read_for_ownership, .snoop_line_state, .store_req,
  .store_grant, .line_state_wr, .line_state_new);

// ### dv/bsec_far_model.sv
`timescale 1ns/1ps
// ==========================================
// bus agents completing transactions, one pulse per class
module bsec_far_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [5:0] go,     // classes to complete next cycle
  input  wire logic       own,    // issued by this core
  output logic      [5:0] ev,     // completion pulses
  output logic      [5:0] own_fl  // owner flags, scrambled when idle
);
  // ==========================================
  // owner flag carries no meaning outside a pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ev     <= 6'h00;
      own_fl <= 6'h00;
    end else begin
      ev     <= go;
      own_fl <= (go & {6{own}}) | (~go & ~own_fl);
    end
  end
endmodule : bsec_far_model

// ### dv/tb_top.sv
`timescale 1ns/1ps
// ==========================================
// bench for the bus and snoop event counter
module tb_top
  import bsec_pkg::*;
;
  logic clk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, irq, rerr, own = 1'h0, store_grant, line_state_wr;
  logic [5:0] go = 6'h0, ev, own_fl;
  logic external_snoop_response_event = 1'h0, snoop_resp_by_self = 1'h0;
  logic snoop_req_by_self = 1'h0, cross_core_snoop_event = 1'h0, read_for_ownership = 1'h0;
  logic [1:0] snoop_resp_type = 2'h0;
  logic store_req = 1'h0, shared_hit_drive_event = 1'h0;
  bsec_line_t snoop_line_state = LN_I, line_state_new;
  int err_total = 0, total_checks = 0, i;
  // class table: code, every-agent, own, expected count
  logic [7:0] code_t [8] = '{EV_PORT_IO, EV_DEFER, EV_LINE, EV_MEMORY, EV_ANY, 8'h71,
                             EV_MEMORY, EV_ANY};
  logic [7:0] all_t = 8'h3F, own_t = 8'h80;
  logic [31:0] exp_t [8] = '{32'h1, 32'h1, 32'h1, 32'h3, 32'h6, 32'h0, 32'h0, 32'h6};
  always #10 clk = ~clk;  // 50 MHz
  // ==========================================
  // design and far side
  bsec_top #(.BUS_DIV(2)) u_dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq,
    .port_io_transaction_event(ev[0]), .port_io_self(own_fl[0]),
    .deferred_transaction_event(ev[1]), .deferred_self(own_fl[1]),
    .full_line_transaction_event(ev[2]), .full_line_self(own_fl[2]),
    .partial_transaction_event(ev[3]), .partial_self(own_fl[3]),
    .invalidate_transaction_event(ev[4]), .invalidate_self(own_fl[4]),
    .other_transaction_event(ev[5]), .other_self(own_fl[5]),
    .external_snoop_response_event, .snoop_resp_type, .snoop_resp_by_self,
    .snoop_req_by_self, .cross_core_snoop_event, .read_for_ownership, .snoop_line_state,
    .store_req, .store_grant, .line_state_wr, .line_state_new, .shared_hit_drive_event);
  bsec_far_model u_far (.clk, .rstn, .go, .own, .ev, .own_fl);
  // ==========================================
  // tasks
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] e);
    total_checks++;
    if (got !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, got);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      err_total++;
      end_of_test();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb
  task automatic rdc(input logic [7:0] a, input string nm, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(nm, rdata, e);
  endtask : rdc
  function automatic logic [31:0] ctl(input logic [7:0] c, input logic a,
                                      input logic [2:0] m, input logic [1:0] x);
    return {17'h0, x, m, a, 1'h1, c};
  endfunction : ctl
  // transaction pulses through the far side
  task automatic tx(input logic [5:0] g, input logic o);
    go <= g;
    own <= o;
    @(posedge clk);
    go <= 6'h0;
    repeat (3) @(posedge clk);
  endtask : tx
  // snoop response pulse; qualifiers flip when idle
  task automatic snp(input logic [1:0] t, input logic r, input logic q);
    external_snoop_response_event <= 1'h1;
    snoop_resp_type <= t;
    snoop_resp_by_self <= r;
    snoop_req_by_self <= q;
    @(posedge clk);
    external_snoop_response_event <= 1'h0;
    snoop_resp_type <= ~t;
    snoop_resp_by_self <= ~r;
    snoop_req_by_self <= ~q;
    @(posedge clk);
  endtask : snp
  // cross-core snoop pulse
  task automatic xc(input logic r, input bsec_line_t s);
    cross_core_snoop_event <= 1'h1;
    read_for_ownership <= r;
    snoop_line_state <= s;
    @(posedge clk);
    cross_core_snoop_event <= 1'h0;
    read_for_ownership <= ~r;
    snoop_line_state <= bsec_line_t'(~s);
    @(posedge clk);
  endtask : xc
  // ==========================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    rdc(OFS_CTRL, "ctrl", 32'h0);
    rdc(OFS_STATUS, "status", 32'h0);
    apb(1'h0, 8'h20, 32'h0);
    chk("unmapped err", {31'h0, rerr}, 32'h1);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      apb(1'h1, OFS_COUNT, 32'h0);
      apb(1'h1, OFS_CTRL, ctl(code_t[i], all_t[i], 3'h0, 2'h0));
      tx(6'h3F, own_t[i]);
      rdc(OFS_COUNT, "class", exp_t[i]);
    end
    $display("test classes done");
    apb(1'h1, OFS_COUNT, 32'h0);
    apb(1'h1, OFS_CTRL, ctl(EV_SNP_RESP, 1'h0, 3'h7, 2'h0));
    for (i = 0; i < 4; i++) snp(2'h1, i[0], i[1]);
    rdc(OFS_COUNT, "own snoop", 32'h1);
    apb(1'h1, OFS_CTRL, ctl(EV_SNP_RESP, 1'h1, 3'h2, 2'h0));
    for (i = 0; i < 4; i++) snp(i[1:0], i[0], ~i[0]);
    rdc(OFS_COUNT, "all snoop", 32'h2);
    $display("test snoop done");
    apb(1'h1, OFS_COUNT, 32'h0);
    apb(1'h1, OFS_ENABLE, 32'h2);
    apb(1'h1, OFS_CTRL, ctl(EV_XCORE, 1'h1, 3'h0, 2'h3));
    store_req <= 1'h1;
    xc(1'h0, LN_E);
    xc(1'h1, LN_S);
    xc(1'h0, LN_M);
    store_req <= 1'h0;
    repeat (2) @(posedge clk);
    chk("defer apply", {29'h0, line_state_wr, line_state_new}, {29'h0, 1'h1, LN_S});
    repeat (2) @(posedge clk);
    rdc(OFS_COUNT, "xcore count", 32'h3);
    chk("defer irq", {31'h0, irq}, 32'h1);
    apb(1'h1, OFS_CLEAR, 32'h2);
    repeat (2) @(posedge clk);
    chk("defer cleared", {31'h0, irq}, 32'h0);
    $display("test cross core done");
    apb(1'h1, OFS_COUNT, 32'h0);
    apb(1'h1, OFS_CTRL, ctl(EV_HIT_DRV, 1'h1, 3'h0, 2'h0));
    shared_hit_drive_event <= 1'h1;
    repeat (6) @(posedge clk);
    shared_hit_drive_event <= 1'h0;
    apb(1'h1, OFS_CTRL, 32'h0);
    rdc(OFS_COUNT, "hit cycles", 32'h3);
    $display("test hit drive done");
    apb(1'h1, OFS_ENABLE, 32'h0);
    apb(1'h1, OFS_COUNT, 32'hFFFFFFFF);
    apb(1'h1, OFS_CTRL, ctl(EV_ANY, 1'h1, 3'h0, 2'h0));
    tx(6'h01, 1'h0);
    rdc(OFS_COUNT, "wrapped", 32'h0);
    rdc(OFS_STATUS, "ovf status", 32'h1);
    chk("masked irq", {31'h0, irq}, 32'h0);
    apb(1'h1, OFS_ENABLE, 32'h1);
    repeat (2) @(posedge clk);
    chk("ovf irq", {31'h0, irq}, 32'h1);
    apb(1'h1, OFS_CLEAR, 32'h1);
    repeat (2) @(posedge clk);
    chk("ovf cleared", {31'h0, irq}, 32'h0);
    $display("test overflow done");
    end_of_test();
  end
endmodule : tb_top
